// *** hw/cdp_ctrl.sv ***
// CAN driver protection controller top level
//
// Contract
// - Normal mode: drive dominant while transmit low, recessive otherwise.
// - Normal/listen: receive follows bus; standby/sleep use wake receiver.
// - Receive output pulled high when transceiver is off.
// - Floating chip select reads high, serial interface deselected.
// - Falling transmit edge starts timeout timer; rising edge clears it.
// - Transmit low for whole timeout period disables bus driver.
// - After timeout fault, driver re-enabled once transmit returns high.
// - During timeout fault receiver stays active, bus biased recessive.
// - Timeout disable bit set switches supervision off entirely.
// - Thermal warning raises an interrupt to the host.
// - Thermal shutdown switches transceiver off, blocking transmit path.
// - Thermal shutdown sets its flag and raises an interrupt.
// - Digital core and serial interface stay working during shutdown.
// - Recheck timer starts at fault; fault gone at expiry means sleep.
// - Protected mode ignores normal/standby writes, accepts sleep writes.
// - With fail-safe enabled, shutdown enters fail-safe instead.
// - Shutdown during I/O undervoltage with fail-safe off enters sleep.
// - Fail-safe enabled after reset; disable bit set turns it off.
`timescale 1ns/100ps
module cdp_ctrl (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire logic                  txd_pin,
  input  wire logic                  txd_pin_oe_n,
  input  wire logic                  bus_dominant,
  input  wire logic                  wake_rx_dominant,
  input  wire logic                  chip_select_n_pin,
  input  wire logic                  chip_select_n_oe_n,
  input  wire logic                  thermal_warn_in,
  input  wire logic                  thermal_shutdown_in,
  input  wire logic                  io_supply_undervoltage,
  input  wire logic                  dominant_timeout_disable,
  input  wire logic                  failsafe_disable,
  input  wire cdp_pkg::cdp_mode_wr_s mode_wr,
  input  wire logic                  flag_clear,
  output logic                       drive_dominant,
  output logic                       bias_recessive,
  output logic                       rxd,
  output logic                       rxd_oe,
  output logic                       chip_select_n,
  output logic                       irq_n,
  output cdp_pkg::cdp_flags_s        flags,
  output cdp_pkg::cdp_state_e        state
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] txd_sync_q;
  logic [1:0] bus_sync_q;
  logic [1:0] wake_sync_q;
  logic [1:0] cs_sync_q;
  logic [1:0] tw_sync_q;
  logic [1:0] hot_sync_q;
  logic [1:0] uv_sync_q;
  logic       txd_raw;
  logic       cs_raw;
  logic       txd_s;
  logic       bus_s;
  logic       wake_s;
  logic       cs_s;
  logic       tw_s;
  logic       hot_s;
  logic       uv_s;

  // Undriven pins read high through the weak pull-ups
  assign txd_raw = txd_pin_oe_n ? 1'b1 : txd_pin;
  assign cs_raw  = chip_select_n_oe_n ? 1'b1 : chip_select_n_pin;

  // Two-stage synchronisers, first stage read only by the second
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      txd_sync_q  <= 2'h3;
      bus_sync_q  <= 2'h0;
      wake_sync_q <= 2'h0;
      cs_sync_q   <= 2'h3;
      tw_sync_q   <= 2'h0;
      hot_sync_q  <= 2'h0;
      uv_sync_q   <= 2'h0;
    end
    else if (clk_en)
    begin
      txd_sync_q  <= {txd_sync_q[0], txd_raw};
      bus_sync_q  <= {bus_sync_q[0], bus_dominant};
      wake_sync_q <= {wake_sync_q[0], wake_rx_dominant};
      cs_sync_q   <= {cs_sync_q[0], cs_raw};
      tw_sync_q   <= {tw_sync_q[0], thermal_warn_in};
      hot_sync_q  <= {hot_sync_q[0], thermal_shutdown_in};
      uv_sync_q   <= {uv_sync_q[0], io_supply_undervoltage};
    end
  end

  assign txd_s  = txd_sync_q[1];
  assign bus_s  = bus_sync_q[1];
  assign wake_s = wake_sync_q[1];
  assign cs_s   = cs_sync_q[1];
  assign tw_s   = tw_sync_q[1];
  assign hot_s  = hot_sync_q[1];
  assign uv_s   = uv_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Dominant-timeout supervisor
  logic tmo_fault;

  cdp_tmo_timer u_tmo (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .txd_s     (txd_s),
    .disable_i (dominant_timeout_disable),
    .fault     (tmo_fault)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine with thermal recheck timer
  cdp_pkg::cdp_state_e       st_q;
  cdp_pkg::cdp_state_e       st_d;
  logic [cdp_pkg::TMR_W-1:0] rchk_q;
  logic [cdp_pkg::TMR_W-1:0] rchk_d;
  logic                      hot_q;
  logic                      hot_rise;
  logic                      protected_st;
  logic                      rchk_done;
  logic                      fs_en;

  assign hot_rise     = hot_s & ~hot_q;
  assign protected_st = (st_q == cdp_pkg::CDP_ST_HOT_PROT) |
                        (st_q == cdp_pkg::CDP_ST_FAILSAFE);
  assign rchk_done    = (rchk_q == cdp_pkg::TMR_W'(cdp_pkg::RECHECK_CYC - 1));
  assign fs_en        = ~failsafe_disable;

  // Next state and recheck timer
  always_comb
  begin
    st_d   = st_q;
    rchk_d = rchk_q;
    if (hot_rise && !protected_st && st_q != cdp_pkg::CDP_ST_SLEEP)
    begin
      rchk_d = '0;
      if (uv_s && !fs_en)
        st_d = cdp_pkg::CDP_ST_SLEEP;
      else if (fs_en)
        st_d = cdp_pkg::CDP_ST_FAILSAFE;
      else
        st_d = cdp_pkg::CDP_ST_HOT_PROT;
    end
    else
    begin
      case (st_q)
        cdp_pkg::CDP_ST_HOT_PROT,
        cdp_pkg::CDP_ST_FAILSAFE:
        begin
          rchk_d = rchk_q + 1'b1;
          if (mode_wr.valid && mode_wr.mode == cdp_pkg::CDP_REQ_SLEEP)
            st_d = cdp_pkg::CDP_ST_SLEEP;
          else if (uv_s && !fs_en)
            st_d = cdp_pkg::CDP_ST_SLEEP;
          else if (rchk_done)
          begin
            rchk_d = '0;
            if (!hot_s)
              st_d = cdp_pkg::CDP_ST_SLEEP;
          end
        end
        cdp_pkg::CDP_ST_NORMAL,
        cdp_pkg::CDP_ST_LISTEN,
        cdp_pkg::CDP_ST_STANDBY,
        cdp_pkg::CDP_ST_SLEEP:
        begin
          if (mode_wr.valid)
          begin
            case (mode_wr.mode)
              cdp_pkg::CDP_REQ_NORMAL:  st_d = cdp_pkg::CDP_ST_NORMAL;
              cdp_pkg::CDP_REQ_LISTEN:  st_d = cdp_pkg::CDP_ST_LISTEN;
              cdp_pkg::CDP_REQ_STANDBY: st_d = cdp_pkg::CDP_ST_STANDBY;
              default:                  st_d = cdp_pkg::CDP_ST_SLEEP;
            endcase
          end
        end
        default: st_d = cdp_pkg::CDP_ST_STANDBY;
      endcase
    end
  end

  // State registers; keep running while in shutdown
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q   <= cdp_pkg::CDP_ST_STANDBY;
      rchk_q <= '0;
      hot_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q   <= st_d;
      rchk_q <= rchk_d;
      hot_q  <= hot_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a new event wins over a clear
  logic tw_q;
  logic tw_rise;
  logic tmo_q;
  logic tmo_rise;
  cdp_pkg::cdp_flags_s flg_d;

  assign tw_rise  = tw_s & ~tw_q;
  assign tmo_rise = tmo_fault & ~tmo_q;
  assign flg_d.thermal_warn     = tw_rise |
                                  (flags.thermal_warn & ~flag_clear);
  assign flg_d.thermal_shutdown = hot_rise |
                                  (flags.thermal_shutdown & ~flag_clear);
  assign flg_d.dominant_timeout = tmo_rise |
                                  (flags.dominant_timeout & ~flag_clear);

  ////////////////////////////////////////////////////////////////////////////
  // Driver and receiver outputs
  logic xcvr_on;
  logic rx_active;
  logic drv_d;
  logic rxd_d;

  assign xcvr_on   = (st_q == cdp_pkg::CDP_ST_NORMAL) |
                     (st_q == cdp_pkg::CDP_ST_LISTEN);
  assign rx_active = xcvr_on |
                     (st_q == cdp_pkg::CDP_ST_STANDBY) |
                     (st_q == cdp_pkg::CDP_ST_SLEEP);
  assign drv_d     = (st_q == cdp_pkg::CDP_ST_NORMAL) & ~txd_s &
                     ~tmo_fault;
  // Main receiver in active modes, wake receiver in low power
  assign rxd_d     = xcvr_on ? ~bus_s : ~wake_s;

  // Registered outputs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tw_q           <= 1'b0;
      tmo_q          <= 1'b0;
      flags          <= '0;
      drive_dominant <= 1'b0;
      bias_recessive <= 1'b0;
      rxd            <= 1'b1;
      rxd_oe         <= 1'b0;
      chip_select_n  <= 1'b1;
      irq_n          <= 1'b1;
      state          <= cdp_pkg::CDP_ST_STANDBY;
    end
    else if (clk_en)
    begin
      tw_q           <= tw_s;
      tmo_q          <= tmo_fault;
      flags          <= flg_d;
      drive_dominant <= drv_d;
      bias_recessive <= xcvr_on & ~drv_d;
      rxd            <= rx_active ? rxd_d : 1'b1;
      rxd_oe         <= rx_active;
      chip_select_n  <= cs_s;
      irq_n          <= ~(flg_d.thermal_warn | flg_d.thermal_shutdown);
      state          <= st_d;
    end
  end

endmodule : cdp_ctrl

// *** shared/cdp_pkg.sv ***
// Package for the CAN driver protection controller: constants and types
package cdp_pkg;

  // Clock rate and timing
  localparam int unsigned CLK_HZ              = 25000000;
  localparam int unsigned TMO_PERIOD_US       = 1200;
  localparam int unsigned TMO_PERIOD_CYC      =
    TMO_PERIOD_US * (CLK_HZ / 1000000);
  localparam int unsigned RECHECK_TIME_MS     = 300;
  localparam longint unsigned RECHECK_CYC_L   =
    longint'(RECHECK_TIME_MS) * longint'(CLK_HZ) / 1000;
  localparam int unsigned RECHECK_CYC         = int'(RECHECK_CYC_L);
  localparam int unsigned TMR_W               = 24;

  // Register bit positions (kept for the host map)
  localparam logic [7:0] REG_TMO_CFG          = 8'h10;
  localparam int unsigned TMO_DIS_BIT         = 6;
  localparam logic [7:0] REG_FS_CFG           = 8'h17;
  localparam int unsigned FS_DIS_BIT          = 0;

  // Reset values
  localparam logic TMO_DIS_RST                = 1'b0;
  localparam logic FS_DIS_RST                 = 1'b0;

  // Mode request codes
  typedef enum logic [1:0] {
    CDP_REQ_NORMAL  = 2'h0,
    CDP_REQ_LISTEN  = 2'h1,
    CDP_REQ_STANDBY = 2'h2,
    CDP_REQ_SLEEP   = 2'h3
  } cdp_req_e;

  // Operating states, one-hot
  typedef enum logic [5:0] {
    CDP_ST_NORMAL   = 6'h01,
    CDP_ST_LISTEN   = 6'h02,
    CDP_ST_STANDBY  = 6'h04,
    CDP_ST_SLEEP    = 6'h08,
    CDP_ST_HOT_PROT = 6'h10,
    CDP_ST_FAILSAFE = 6'h20
  } cdp_state_e;

  // Mode write request from the host side
  typedef struct packed {
    logic     valid;
    cdp_req_e mode;
  } cdp_mode_wr_s;

  // Fault and status flags shown to the host
  typedef struct packed {
    logic thermal_warn;
    logic thermal_shutdown;
    logic dominant_timeout;
  } cdp_flags_s;

endpackage : cdp_pkg

// *** hw/cdp_dto_timer.sv ***
// Dominant-timeout supervisor on the transmit input
`timescale 1ns/100ps
module cdp_tmo_timer (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic txd_s,
  input  wire logic disable_i,
  output logic      fault
);

  logic [cdp_pkg::TMR_W-1:0] cnt_q;
  logic                      txd_q;
  logic                      fall;
  logic                      done;

  assign fall = txd_q & ~txd_s;
  assign done = (cnt_q == cdp_pkg::TMR_W'(cdp_pkg::TMO_PERIOD_CYC - 1));

  // Counter runs from a falling edge while the input stays low
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      txd_q <= 1'b1;
      fault <= 1'b0;
    end
    else if (clk_en)
    begin
      txd_q <= txd_s;
      if (disable_i)
      begin
        cnt_q <= '0;
        fault <= 1'b0;
      end
      else if (txd_s)
      begin
        cnt_q <= '0;
        fault <= 1'b0;
      end
      else if (fall)
        cnt_q <= '0;
      else if (!fault)
      begin
        cnt_q <= cnt_q + 1'b1;
        if (done)
          fault <= 1'b1;
      end
    end
  end

endmodule : cdp_tmo_timer

// *** test/cdp_bus_model.sv ***
// Bus model: own driver plus the other nodes on the wire
`timescale 1ns/100ps
module cdp_bus_model (
  input  wire logic drive_dominant,
  input  wire logic other_dom,
  output logic      bus_dominant
);
  // Any dominant driver wins; a released bus reads recessive
  assign bus_dominant = drive_dominant | other_dom;
endmodule : cdp_bus_model

// *** test/cdp_ctrl_checker.sv ***
// Checker on the protection controller ports
`timescale 1ns/100ps
module cdp_ctrl_checker (
  input wire logic                core_clk,
  input wire logic                rst,
  input wire logic                thermal_shutdown_in,
  input wire logic                failsafe_disable,
  input wire logic                io_supply_undervoltage,
  input wire logic                chip_select_n_oe_n,
  input wire logic                drive_dominant,
  input wire logic                bias_recessive,
  input wire logic                rxd,
  input wire logic                rxd_oe,
  input wire logic                chip_select_n,
  input wire logic                irq_n,
  input wire cdp_pkg::cdp_flags_s flags,
  input wire cdp_pkg::cdp_state_e state
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Driver and bias per mode once the mode has settled; receive pull-up and chip select default
  chk_quiet_no_drive: assert property (
    state inside {cdp_pkg::CDP_ST_LISTEN, cdp_pkg::CDP_ST_STANDBY,
    cdp_pkg::CDP_ST_SLEEP} && state == $past(state) |-> !drive_dominant)
    else $error("driver on in a quiet mode");
  chk_hot_off: assert property (
    state inside {cdp_pkg::CDP_ST_HOT_PROT, cdp_pkg::CDP_ST_FAILSAFE}
    && state == $past(state) |-> !drive_dominant && !bias_recessive)
    else $error("transceiver on during shutdown");
  chk_idle_bias: assert property (
    state == cdp_pkg::CDP_ST_NORMAL && $past(state) == state
    && !drive_dominant |-> bias_recessive)
    else $error("normal mode bus not biased");
  chk_rxd_pull: assert property (!rxd_oe |-> rxd)
    else $error("receive output low while released");
  chk_cs_float: assert property (
    chip_select_n_oe_n [*4] |-> chip_select_n)
    else $error("floating chip select selects");
  // Thermal events: flag, interrupt and next state
  chk_hot_flag: assert property (
    $rose(thermal_shutdown_in) |-> ##[1:4] flags.thermal_shutdown)
    else $error("shutdown flag missing");
  chk_irq_low: assert property (
    flags.thermal_warn || flags.thermal_shutdown |-> ##[0:1] !irq_n)
    else $error("interrupt not raised");
  chk_fs_entry: assert property (
    $rose(thermal_shutdown_in) && !failsafe_disable
    |-> ##[1:4] state == cdp_pkg::CDP_ST_FAILSAFE)
    else $error("fail-safe not entered");
  chk_uv_sleep: assert property (
    $rose(thermal_shutdown_in) && failsafe_disable && io_supply_undervoltage
    |-> ##[1:4] state == cdp_pkg::CDP_ST_SLEEP)
    else $error("sleep not entered");
endmodule : cdp_ctrl_checker
bind cdp_ctrl cdp_ctrl_checker i_chk (.core_clk, .rst, .thermal_shutdown_in,
  .failsafe_disable, .io_supply_undervoltage, .chip_select_n_oe_n,
  .drive_dominant, .bias_recessive, .rxd, .rxd_oe, .chip_select_n, .irq_n,
  .flags, .state);

// *** test/tb_cdp_ctrl.sv ***
// Self-checking bench for the protection controller
`timescale 1ns/100ps
module tb_cdp_ctrl;
  logic core_clk, rst, clk_en, txd_pin, txd_pin_oe_n, bus_dominant;
  logic wake_rx_dominant, chip_select_n_pin, chip_select_n_oe_n, other_dom;
  logic thermal_warn_in, thermal_shutdown_in, io_supply_undervoltage;
  logic dominant_timeout_disable, failsafe_disable, flag_clear;
  logic drive_dominant, bias_recessive, rxd, rxd_oe, chip_select_n, irq_n;
  cdp_pkg::cdp_mode_wr_s mode_wr;
  cdp_pkg::cdp_flags_s   flags;
  cdp_pkg::cdp_state_e   state;
  cdp_pkg::cdp_state_e   mst;
  logic [31:0]           seed;
  int                    error_cnt, comparisons, hold;
  localparam int         TMO_CYC = cdp_pkg::TMO_PERIOD_CYC;
  cdp_ctrl i_dut (.core_clk, .rst, .clk_en, .txd_pin, .txd_pin_oe_n,
    .bus_dominant, .wake_rx_dominant, .chip_select_n_pin, .chip_select_n_oe_n,
    .thermal_warn_in, .thermal_shutdown_in, .io_supply_undervoltage,
    .dominant_timeout_disable, .failsafe_disable, .mode_wr, .flag_clear,
    .drive_dominant, .bias_recessive, .rxd, .rxd_oe, .chip_select_n, .irq_n,
    .flags, .state);
  cdp_bus_model i_bus (.drive_dominant, .other_dom, .bus_dominant);
  ////////////////////////////////////////////////////////////
  // Clock source
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic obs(input int n);
    cyc(n);
    #1;
  endtask : obs
  // Mode write plus model update; protected states take only sleep
  task automatic wr(input cdp_pkg::cdp_req_e m);
    cyc(1);
    mode_wr <= '{1'b1, m};
    cyc(1);
    mode_wr.valid <= 1'b0;
    if (!(mst inside {6'h10, 6'h20}) || m == cdp_pkg::CDP_REQ_SLEEP)
      mst = cdp_pkg::cdp_state_e'(6'h01 << m);
  endtask : wr
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  // Main sequence
  initial
  begin
    seed = 32'h5;
    {rst, clk_en, txd_pin_oe_n, chip_select_n_oe_n} = 4'hF;
    {txd_pin, chip_select_n_pin, other_dom, wake_rx_dominant} = 4'h0;
    {thermal_warn_in, thermal_shutdown_in, io_supply_undervoltage} = 3'h0;
    {dominant_timeout_disable, failsafe_disable, flag_clear} = 3'h0;
    mode_wr = '0;
    mst = cdp_pkg::CDP_ST_STANDBY;
    cyc(12);
    rst <= 1'b0;
    obs(6);
    chk(state, mst);
    chk(rxd, 1);
    chk(chip_select_n, 1);
    chk(drive_dominant, 0);
    cyc(1);
    txd_pin_oe_n <= 1'b0;
    other_dom <= 1'b1;
    // Standby listens through the wake receiver only
    obs(6);
    chk(rxd, 1);
    cyc(1);
    wake_rx_dominant <= 1'b1;
    obs(6);
    chk(rxd, 0);
    wr(cdp_pkg::CDP_REQ_LISTEN);
    obs(8);
    chk(drive_dominant, 0);
    chk(rxd, 0);
    wr(cdp_pkg::CDP_REQ_NORMAL);
    for (int i = 0; i < 40; i++)
    begin
      cyc(1);
      seed = rnd(seed);
      txd_pin <= seed[0];
      other_dom <= seed[1];
      obs(8);
      chk(drive_dominant, !seed[0]);
      chk(rxd, seed[0] & !seed[1]);
    end
    cyc(1);
    txd_pin <= 1'b0;
    other_dom <= 1'b0;
    txd_pin_oe_n <= 1'b1;
    obs(8);
    chk(drive_dominant, 0);
    // Long dominant: fault, bus watch, recovery
    cyc(1);
    txd_pin_oe_n <= 1'b0;
    obs(TMO_CYC + 50);
    chk(drive_dominant, 0);
    chk(bias_recessive, 1);
    chk(flags, 3'h1);
    cyc(1);
    other_dom <= 1'b1;
    obs(8);
    chk(rxd, 0);
    cyc(1);
    {txd_pin, other_dom} <= 2'b10;
    flag_clear <= 1'b1;
    cyc(1);
    flag_clear <= 1'b0;
    txd_pin <= 1'b0;
    obs(8);
    chk(drive_dominant, 1);
    chk(flags, 3'h0);
    // Two short low runs, then a long one with supervision off
    for (int k = 0; k < 3; k++)
    begin
      cyc(1);
      txd_pin <= 1'b1;
      cyc(4);
      txd_pin <= 1'b0;
      dominant_timeout_disable <= (k == 2);
      hold = (k == 2) ? TMO_CYC + 50 : TMO_CYC * 3 / 5;
      obs(hold);
      chk(drive_dominant, 1);
    end
    cyc(1);
    {txd_pin, dominant_timeout_disable, thermal_warn_in} <= 3'b101;
    obs(6);
    chk(flags, 3'h4);
    chk(irq_n, 0);
    // Clock enable low freezes the transmit path
    cyc(1);
    clk_en <= 1'b0;
    txd_pin <= 1'b0;
    obs(8);
    chk(drive_dominant, 0);
    cyc(1);
    clk_en <= 1'b1;
    obs(8);
    chk(drive_dominant, 1);
    // Shutdown: fail-safe, protected, and with undervoltage
    for (int k = 0; k < 3; k++)
    begin
      cyc(1);
      {thermal_warn_in, failsafe_disable} <= {1'b0, k > 0};
      io_supply_undervoltage <= (k > 1);
      wr(cdp_pkg::CDP_REQ_NORMAL);
      cyc(1);
      {txd_pin, thermal_shutdown_in} <= 2'b01;
      obs(6);
      mst = (k == 0) ? cdp_pkg::CDP_ST_FAILSAFE : (k == 1) ?
        cdp_pkg::CDP_ST_HOT_PROT : cdp_pkg::CDP_ST_SLEEP;
      chk(state, mst);
      chk(drive_dominant, 0);
      chk(flags[1], 1);
      chk(irq_n, 0);
      if (k < 2)
      begin
        wr(cdp_pkg::CDP_REQ_NORMAL);
        wr(cdp_pkg::CDP_REQ_STANDBY);
        cyc(1);
        chip_select_n_oe_n <= 1'b0;
        obs(6);
        chk(state, mst);
        chk(chip_select_n, 0);
        chk(rxd_oe, 0);
        chk(rxd, 1);
        wr(cdp_pkg::CDP_REQ_SLEEP);
        obs(2);
        chk(state, mst);
      end
      cyc(1);
      {rst, chip_select_n_oe_n, thermal_shutdown_in} <= 3'b110;
      cyc(12);
      rst <= 1'b0;
      mst = cdp_pkg::CDP_ST_STANDBY;
    end
    results();
  end
endmodule : tb_cdp_ctrl
